// *** common/atc_params.svh ***
// Constants for the accumulator-to-control-register transfer decoder
`ifndef ATC_PARAMS_SVH
`define ATC_PARAMS_SVH

// ==========================================================
// Instruction codes
`define ATC_OP_W            10
`define ATC_OP_IRQ_CTRL     10'h217
`define ATC_OP_SERIAL_CTRL  10'h202
`define ATC_OP_WAKE_FIRST   10'h21B
`define ATC_OP_WAKE_SECOND  10'h214
`define ATC_OP_WAKE_THIRD   10'h215

// ==========================================================
// Data widths
`define ATC_ACC_W           4
`define ATC_NUM_DEST        5
`define ATC_CNT_W           8

// ==========================================================
// Register byte offsets
`define ATC_OFS_CTRL        12'h000
`define ATC_OFS_STATUS      12'h004
`define ATC_OFS_IRQ         12'h008
`define ATC_OFS_SERIAL      12'h00C
`define ATC_OFS_WAKE0       12'h010
`define ATC_OFS_WAKE1       12'h014
`define ATC_OFS_WAKE2       12'h018

// ==========================================================
// Field positions and reset values
`define ATC_CTRL_EN_BIT     0
`define ATC_CTRL_CLR_BIT    1
`define ATC_CTRL_RST        1'h1
`define ATC_STAT_SEL_LSB    0
`define ATC_STAT_CNT_LSB    8
`define ATC_CREG_RST        4'h0

`endif

// *** common/atc_pkg.sv ***
// Types shared by the transfer decoder and its surroundings
package atc_pkg;

  // ==========================================================
  // Fetched instruction as handed over by the fetch stage
  typedef struct packed {
    logic       valid;
    logic [9:0] code;
  } atc_instr_t;

  // ==========================================================
  // Peripheral control registers written by the transfers
  typedef struct packed {
    logic [3:0] irq_ctrl_reg;
    logic [3:0] serial_ctrl_reg;
    logic [3:0] wake_ctrl_first;
    logic [3:0] wake_ctrl_second;
    logic [3:0] wake_ctrl_third;
  } atc_ctrl_regs_t;

  // ==========================================================
  // One-hot destination select, bit order matches the struct above
  typedef enum logic [4:0] {
    ATC_DEST_NONE   = 5'h00,
    ATC_DEST_THIRD  = 5'h01,
    ATC_DEST_SECOND = 5'h02,
    ATC_DEST_FIRST  = 5'h04,
    ATC_DEST_SERIAL = 5'h08,
    ATC_DEST_IRQ    = 5'h10
  } atc_dest_t;

endpackage

// *** rtl/atc_xfer_decode.sv ***
// Decoder and executor for accumulator-to-control-register transfers, with APB view
//
// How it works
// - opcode 217h copies accumulator to irq_ctrl_reg
// - opcode 202h copies accumulator to serial_ctrl_reg
// - opcode 21Bh copies accumulator to wake_ctrl_first
// - opcode 214h copies accumulator to wake_ctrl_second
// - opcode 215h copies accumulator to wake_ctrl_third
//
// Our own choices: the APB register port and the register addresses.
`timescale 1ns/1ps
`include "atc_params.svh"

module atc_xfer_decode #(
  parameter int ACC_W = `ATC_ACC_W,
  parameter int CNT_W = `ATC_CNT_W
) (
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  // APB register port
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [11:0]             paddr,
  input  wire logic [31:0]             pwdata,
  output logic                         pready,
  output logic [31:0]                  prdata,
  output logic                         pslverr,
  // Instruction stream and core state from fetch
  input  wire atc_pkg::atc_instr_t     instr,
  input  wire logic [ACC_W-1:0]        acc_val,
  input  wire logic                    carry_flag,
  // Results towards the peripherals and the core
  output atc_pkg::atc_ctrl_regs_t      ctrl_regs,
  output logic                         xfer_done,
  output logic [`ATC_NUM_DEST-1:0]     xfer_dest,
  output logic                         skip_next,
  output logic                         carry_flag_out
);

  // ==========================================================
  // Opcode decode
  // Only an exact ten-bit match selects a register; every other code, the
  // neighbouring port and timer transfers included, falls to the default
  function automatic atc_pkg::atc_dest_t dest_of(input logic [`ATC_OP_W-1:0] op);
    atc_pkg::atc_dest_t d;
    d = atc_pkg::ATC_DEST_NONE;
    unique case (op)
      `ATC_OP_IRQ_CTRL:    d = atc_pkg::ATC_DEST_IRQ;
      `ATC_OP_SERIAL_CTRL: d = atc_pkg::ATC_DEST_SERIAL;
      `ATC_OP_WAKE_FIRST:  d = atc_pkg::ATC_DEST_FIRST;
      `ATC_OP_WAKE_SECOND: d = atc_pkg::ATC_DEST_SECOND;
      `ATC_OP_WAKE_THIRD:  d = atc_pkg::ATC_DEST_THIRD;
      default:             d = atc_pkg::ATC_DEST_NONE;
    endcase
    return d;
  endfunction

  // Readback of a four-bit control register as a bus word
  function automatic logic [31:0] word_of(input logic [3:0] f);
    return {28'h0, f};
  endfunction

  // ==========================================================
  // Register state
  logic                            dec_en_ff;
  logic                            nxt_dec_en;
  atc_pkg::atc_ctrl_regs_t         ctrl_ff;
  atc_pkg::atc_ctrl_regs_t         nxt_ctrl;
  logic                            done_ff;
  logic [`ATC_NUM_DEST-1:0]        dest_ff;
  logic [`ATC_NUM_DEST-1:0]        last_dest_ff;
  logic [`ATC_NUM_DEST-1:0]        nxt_last_dest;
  logic [CNT_W-1:0]                exec_cnt_ff;
  logic [CNT_W-1:0]                nxt_exec_cnt;
  logic                            carry_ff;
  logic                            pready_ff;
  logic [31:0]                     prdata_ff;
  logic                            pslverr_ff;
  logic                            skip_ff;
  logic                            nxt_pready;
  logic [31:0]                     nxt_prdata;
  logic                            nxt_pslverr;

  // ==========================================================
  // Execute path
  atc_pkg::atc_dest_t              dec_dest;
  logic [`ATC_NUM_DEST-1:0]        wr_sel;
  logic                            exec_hit;
  logic [3:0]                      acc_nib;
  logic                            wr_irq;
  logic                            wr_serial;
  logic                            wr_first;
  logic                            wr_second;
  logic                            wr_third;

  // With decode disabled a matching code is let through untouched, as if unknown
  assign dec_dest = dest_of(instr.code);
  assign exec_hit = instr.valid & dec_en_ff & (dec_dest != atc_pkg::ATC_DEST_NONE);
  // At most one select bit is ever set, so a single field can change per cycle
  assign wr_sel   = exec_hit ? dec_dest : atc_pkg::ATC_DEST_NONE;
  // The control registers hold four bits; a wider accumulator is cut here
  assign acc_nib  = acc_val[3:0];

  assign wr_irq    = wr_sel[4];
  assign wr_serial = wr_sel[3];
  assign wr_first  = wr_sel[2];
  assign wr_second = wr_sel[1];
  assign wr_third  = wr_sel[0];

  // Each destination takes the accumulator only when its own select bit is set;
  // the accumulator is an input here, so no path exists to alter it
  assign nxt_ctrl.irq_ctrl_reg     = wr_irq    ? acc_nib : ctrl_ff.irq_ctrl_reg;
  assign nxt_ctrl.serial_ctrl_reg  = wr_serial ? acc_nib : ctrl_ff.serial_ctrl_reg;
  assign nxt_ctrl.wake_ctrl_first  = wr_first  ? acc_nib : ctrl_ff.wake_ctrl_first;
  assign nxt_ctrl.wake_ctrl_second = wr_second ? acc_nib : ctrl_ff.wake_ctrl_second;
  assign nxt_ctrl.wake_ctrl_third  = wr_third  ? acc_nib : ctrl_ff.wake_ctrl_third;

  assign nxt_last_dest = exec_hit ? wr_sel : last_dest_ff;

  // ==========================================================
  // APB decode
  // Register map, one aligned word each, unused bits read as 0:
  //   CTRL    bit 0 decode enable, set out of reset
  //           bit 1 write 1 to clear the transfer count, reads 0
  //   STATUS  bits 4:0 destination of the last transfer
  //           bits 15:8 transfers executed, wrapping
  //   IRQ     bits 3:0 irq_ctrl_reg
  //   SERIAL  bits 3:0 serial_ctrl_reg
  //   WAKE0   bits 3:0 wake_ctrl_first
  //   WAKE1   bits 3:0 wake_ctrl_second
  //   WAKE2   bits 3:0 wake_ctrl_third
  // Writes to any other mapped register are dropped without error, so software cannot
  // race the core for a control register; an unmapped address answers pslverr
  logic                            apb_setup;
  logic                            apb_done;
  logic                            hit_ctrl;
  logic                            hit_status;
  logic                            hit_irq;
  logic                            hit_serial;
  logic                            hit_wake0;
  logic                            hit_wake1;
  logic                            hit_wake2;
  logic                            addr_ok;
  logic                            ctrl_wr;
  logic                            cnt_clr;
  logic [31:0]                     rd_mux;
  logic [31:0]                     status_word;

  // One wait state keeps pready and prdata straight from flops: the first edge
  // with psel and penable high loads the response, pready stands in the second
  // access cycle, and apb_done marks the edge that ends it and commits a write
  assign apb_setup  = psel & penable & ~pready_ff;
  assign apb_done   = psel & penable & pready_ff;
  assign hit_ctrl   = paddr == `ATC_OFS_CTRL;
  assign hit_status = paddr == `ATC_OFS_STATUS;
  assign hit_irq    = paddr == `ATC_OFS_IRQ;
  assign hit_serial = paddr == `ATC_OFS_SERIAL;
  assign hit_wake0  = paddr == `ATC_OFS_WAKE0;
  assign hit_wake1  = paddr == `ATC_OFS_WAKE1;
  assign hit_wake2  = paddr == `ATC_OFS_WAKE2;
  assign addr_ok    = hit_ctrl | hit_status | hit_irq | hit_serial | hit_wake0 | hit_wake1 | hit_wake2;

  // Only the control word is writable; the control registers belong to the CPU
  assign ctrl_wr    = apb_done & pwrite & hit_ctrl & ~pslverr_ff;
  assign nxt_dec_en = ctrl_wr ? pwdata[`ATC_CTRL_EN_BIT] : dec_en_ff;
  assign cnt_clr    = ctrl_wr & pwdata[`ATC_CTRL_CLR_BIT];

  // A transfer in the clearing cycle is still counted, so none is lost
  // The count wraps at its width; software is expected to sample it often
  assign nxt_exec_cnt = exec_hit ? (cnt_clr ? CNT_W'(1) : CNT_W'(exec_cnt_ff + 1'b1))
                                 : (cnt_clr ? '0 : exec_cnt_ff);

  // Last destination in the low byte, transfer count in the byte above it
  assign status_word = {{(32 - `ATC_STAT_CNT_LSB - CNT_W){1'b0}}, exec_cnt_ff,
                        {(`ATC_STAT_CNT_LSB - `ATC_NUM_DEST){1'b0}}, last_dest_ff};

  assign rd_mux = hit_ctrl   ? {31'h0, dec_en_ff} :
                  hit_status ? status_word :
                  hit_irq    ? word_of(ctrl_ff.irq_ctrl_reg) :
                  hit_serial ? word_of(ctrl_ff.serial_ctrl_reg) :
                  hit_wake0  ? word_of(ctrl_ff.wake_ctrl_first) :
                  hit_wake1  ? word_of(ctrl_ff.wake_ctrl_second) :
                  hit_wake2  ? word_of(ctrl_ff.wake_ctrl_third) :
                               32'h0000_0000;

  // Response for the access phase, registered one cycle later
  assign nxt_pready  = apb_setup;
  assign nxt_prdata  = (apb_setup & ~pwrite & addr_ok) ? rd_mux : 32'h0000_0000;
  assign nxt_pslverr = apb_setup & ~addr_ok;

  // ==========================================================
  // Control registers
  // The whole bank loads every cycle; fields not selected reload their own value
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_ff <= '0;
    end
    else
    begin
      ctrl_ff <= nxt_ctrl;
    end
  end

  // ==========================================================
  // Execute pulse, standing for the one cycle after the instruction edge
  // skip_next is a flop that stays low: none of these transfers skips, but the
  // core still sees a registered output with the same timing as xfer_done
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      done_ff <= 1'b0;
      dest_ff <= '0;
      skip_ff <= 1'b0;
    end
    else
    begin
      done_ff <= exec_hit;
      dest_ff <= wr_sel;
      skip_ff <= 1'b0;
    end
  end

  // ==========================================================
  // Execute history for the status word
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      last_dest_ff <= '0;
      exec_cnt_ff  <= '0;
    end
    else
    begin
      last_dest_ff <= nxt_last_dest;
      exec_cnt_ff  <= nxt_exec_cnt;
    end
  end

  // These transfers never skip and never touch carry: carry is passed on as is
  // Delaying carry by one cycle keeps it aligned with xfer_done for the core
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      carry_ff <= 1'b0;
    end
    else
    begin
      carry_ff <= carry_flag;
    end
  end

  // ==========================================================
  // Decode enable, the only bit software can write and read back
  // Clearing it parks the decoder, so code can run without touching the peripherals
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      dec_en_ff <= `ATC_CTRL_RST;
    end
    else
    begin
      dec_en_ff <= nxt_dec_en;
    end
  end

  // ==========================================================
  // APB slave response
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_ff  <= 1'b0;
      prdata_ff  <= 32'h0000_0000;
      pslverr_ff <= 1'b0;
    end
    else
    begin
      pready_ff  <= nxt_pready;
      prdata_ff  <= nxt_prdata;
      pslverr_ff <= nxt_pslverr;
    end
  end

  // ==========================================================
  // Outputs
  // Each output is a flop; these assigns only give the flops their port names
  assign pready         = pready_ff;
  assign prdata         = prdata_ff;
  assign pslverr        = pslverr_ff;
  assign ctrl_regs      = ctrl_ff;
  assign xfer_done      = done_ff;
  assign xfer_dest      = dest_ff;
  assign skip_next      = skip_ff;
  assign carry_flag_out = carry_ff;

endmodule

// *** sim/atc_xfer_decode_checker.sv ***
// Concurrent checks on the transfer decoder ports
`timescale 1ns/1ps

module atc_xfer_decode_checker #(
  parameter int ACC_W = 4
) (
  input wire logic                    pclk,
  input wire logic                    presetn,
  input wire atc_pkg::atc_instr_t     instr,
  input wire logic [ACC_W-1:0]        acc_val,
  input wire logic                    carry_flag,
  input wire atc_pkg::atc_ctrl_regs_t ctrl_regs,
  input wire logic                    xfer_done,
  input wire logic [4:0]              xfer_dest,
  input wire logic                    skip_next,
  input wire logic                    carry_flag_out
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ==========================================================
  // Each pulse must trace back to its opcode and copied value
  property p_irq;
    xfer_done && xfer_dest == 5'h10 |-> $past(instr) == {1'b1, 10'h217} && ctrl_regs[19:16] == $past(acc_val);
  endproperty
  a_irq: assert property (p_irq) else $error("irq transfer wrong");
  property p_ser;
    xfer_done && xfer_dest == 5'h08 |-> $past(instr) == {1'b1, 10'h202} && ctrl_regs[15:12] == $past(acc_val);
  endproperty
  a_ser: assert property (p_ser) else $error("serial transfer wrong");
  property p_wk0;
    xfer_done && xfer_dest == 5'h04 |-> $past(instr) == {1'b1, 10'h21B} && ctrl_regs[11:8] == $past(acc_val);
  endproperty
  a_wk0: assert property (p_wk0) else $error("first wake transfer wrong");
  property p_wk1;
    xfer_done && xfer_dest == 5'h02 |-> $past(instr) == {1'b1, 10'h214} && ctrl_regs[7:4] == $past(acc_val);
  endproperty
  a_wk1: assert property (p_wk1) else $error("second wake transfer wrong");
  property p_wk2;
    xfer_done && xfer_dest == 5'h01 |-> $past(instr) == {1'b1, 10'h215} && ctrl_regs[3:0] == $past(acc_val);
  endproperty
  a_wk2: assert property (p_wk2) else $error("third wake transfer wrong");
  property p_keep;
    !xfer_done |-> $stable(ctrl_regs) && xfer_dest == 5'h00;
  endproperty
  a_keep: assert property (p_keep) else $error("registers moved without transfer");
  property p_dest;
    xfer_done |-> $onehot(xfer_dest);
  endproperty
  a_dest: assert property (p_dest) else $error("destination not one-hot");
  property p_cy;
    $past(presetn) |-> carry_flag_out == $past(carry_flag) && !skip_next;
  endproperty
  a_cy: assert property (p_cy) else $error("carry or skip altered");
endmodule

bind atc_xfer_decode atc_xfer_decode_checker #(.ACC_W(ACC_W)) i_atc_xfer_decode_checker (.pclk, .presetn,
  .instr, .acc_val, .carry_flag, .ctrl_regs, .xfer_done, .xfer_dest, .skip_next, .carry_flag_out);

// *** sim/atc_xfer_decode_tb_top.sv ***
// Self-checking bench for the transfer decoder
`timescale 1ns/1ps
`include "atc_params.svh"

module atc_xfer_decode_tb_top;
  logic                    pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic                    carry_flag, xfer_done, skip_next, carry_flag_out;
  logic [11:0]             paddr;
  logic [31:0]             pwdata, prdata, rd;
  logic [3:0]              acc_val;
  logic [4:0]              xfer_dest;
  atc_pkg::atc_instr_t     instr;
  atc_pkg::atc_ctrl_regs_t ctrl_regs, exp_regs;
  int                      n_fail, total_checks, cycles;

  atc_xfer_decode i_atc_xfer_decode (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .instr(instr), .acc_val(acc_val), .carry_flag(carry_flag), .ctrl_regs(ctrl_regs), .xfer_done(xfer_done),
    .xfer_dest(xfer_dest), .skip_next(skip_next), .carry_flag_out(carry_flag_out));

  // ==========================================================
  // Shared tasks
  task conclude;
    if (n_fail == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("unexpected %s: expected %h, seen %h", name, exp, got);
    end
  endtask

  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // ==========================================================
  // Scenarios
  task t_regs;
    apb(1'b0, `ATC_OFS_CTRL, 32'h0);
    chk("ctrl reset", 32'h1, rd);
    apb(1'b0, `ATC_OFS_IRQ, 32'h0);
    chk("irq reset", 32'h0, rd);
    apb(1'b1, 12'hFFC, 32'h5);
    chk("unmapped err", 32'h1, err);
  endtask

  // Back to back, with a near-miss opcode in the middle
  task t_exec;
    logic [9:0] codes [6];
    logic [3:0] accs [6];
    logic [4:0] dest;
    codes = '{10'h217, 10'h202, 10'h216, 10'h21B, 10'h214, 10'h215};
    accs = '{4'hA, 4'h5, 4'hF, 4'h3, 4'hC, 4'h9};
    for (int i = 0; i <= 6; i++)
    begin
      @(posedge pclk);
      instr <= (i < 6) ? {1'b1, codes[i % 6]} : 11'h0;
      acc_val <= accs[i % 6];
      carry_flag <= i[0];
      if (i > 0)
      begin
        #1;
        dest = 5'h00;
        case (codes[i-1])
          10'h217: begin exp_regs.irq_ctrl_reg = accs[i-1]; dest = 5'h10; end
          10'h202: begin exp_regs.serial_ctrl_reg = accs[i-1]; dest = 5'h08; end
          10'h21B: begin exp_regs.wake_ctrl_first = accs[i-1]; dest = 5'h04; end
          10'h214: begin exp_regs.wake_ctrl_second = accs[i-1]; dest = 5'h02; end
          10'h215: begin exp_regs.wake_ctrl_third = accs[i-1]; dest = 5'h01; end
          default: dest = 5'h00;
        endcase
        chk("regs", exp_regs, ctrl_regs);
        chk("done", dest != 5'h00, xfer_done);
        chk("dest", dest, xfer_dest);
        chk("carry", i[0] ^ 1'b1, carry_flag_out);
        chk("skip", 32'h0, skip_next);
      end
    end
  endtask

  task t_status;
    apb(1'b0, `ATC_OFS_STATUS, 32'h0);
    chk("status", 32'h501, rd);
    apb(1'b1, `ATC_OFS_SERIAL, 32'hF);
    apb(1'b0, `ATC_OFS_SERIAL, 32'h0);
    chk("serial rd", 32'h5, rd);
  endtask

  // Decode disabled: a matching code passes untouched; clear then zeroes the count
  task t_ctrl;
    apb(1'b1, `ATC_OFS_CTRL, 32'h0);
    @(posedge pclk);
    instr <= {1'b1, 10'h217};
    acc_val <= 4'h6;
    @(posedge pclk);
    instr <= '0;
    #1;
    chk("off done", 32'h0, xfer_done);
    chk("off regs", exp_regs, ctrl_regs);
    apb(1'b1, `ATC_OFS_CTRL, 32'h3);
    apb(1'b0, `ATC_OFS_CTRL, 32'h0);
    chk("ctrl rd", 32'h1, rd);
    apb(1'b0, `ATC_OFS_STATUS, 32'h0);
    chk("cleared", 32'h1, rd);
  endtask

  // ==========================================================
  // Main sequence and hang guard
  initial
  begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      n_fail++;
      conclude();
    end
  end

  initial
  begin
    {presetn, psel, penable, pwrite, carry_flag} = 5'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
    acc_val = 4'h0;
    instr = '0;
    exp_regs = '0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_exec();
    t_status();
    t_ctrl();
    conclude();
  end
endmodule
